// File: rtl/eiu_pkg.sv
package eiu_pkg;

  // ==========================================================
  // register addresses on the special function register port
  localparam logic [7:0] EIU_ADDR_STD_MASK  = 8'hA8;
  localparam logic [7:0] EIU_ADDR_STD_LEVEL = 8'hB8;
  localparam logic [7:0] EIU_ADDR_FLAGS     = 8'h91;
  localparam logic [7:0] EIU_ADDR_CONTROL   = 8'hD8;
  localparam logic [7:0] EIU_ADDR_ENABLES   = 8'hE8;
  localparam logic [7:0] EIU_ADDR_LEVELS    = 8'hF8;

  // ==========================================================
  // field positions and fixed read values
  localparam int unsigned EIU_GATE_BIT      = 7;
  localparam int unsigned EIU_FLAGS_LSB     = 4;
  localparam int unsigned EIU_WAKE_BIT      = 3;
  localparam logic [3:0]  EIU_FLAGS_FIXED   = 4'h8;
  localparam logic [1:0]  EIU_CTRL_TOP      = 2'h1;
  localparam logic [2:0]  EIU_EXT_TOP       = 3'h7;
  localparam logic [1:0]  EIU_STD_MASK_TOP  = 2'h0;
  localparam logic [1:0]  EIU_STD_LEVEL_TOP = 2'h2;
  localparam logic [7:0]  EIU_UNMAPPED_READ = 8'h00;

  // ==========================================================
  // source counts, reset values and vectors
  localparam int unsigned EIU_NUM_STD = 6;
  localparam int unsigned EIU_NUM_EXT = 5;
  localparam int unsigned EIU_NUM_SRC = EIU_NUM_STD + EIU_NUM_EXT;
  localparam logic [4:0]  EIU_EXT_RESET  = 5'h00;
  localparam logic [5:0]  EIU_STD_RESET  = 6'h00;
  localparam logic [7:0]  EIU_STD_VEC_BASE = 8'h03;
  localparam logic [7:0]  EIU_EXT_VEC_BASE = 8'h43;
  localparam logic [7:0]  EIU_VEC_STEP     = 8'h08;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } eiu_sfr_req_t;

endpackage

// File: rtl/eiu_rise_det.sv
`timescale 1ns/1ps
module eiu_rise_det #(
  parameter int unsigned W = 5
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out
);

  // ==========================================================
  // previous level, rise is high for one cycle
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  always_comb begin
    prev_d = level_in;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise_out = level_in & ~prev_q;

endmodule

// File: rtl/eiu_top.sv
// What this block does
// - spi byte done sets flag bit five
// - converter done rise sets flag bit four
// - software clears flags; software set raises interrupt
// - reserved bits read fixed ones and zeros
// - wake event sets control bit three
// - software set wake flag raises interrupt
// - enable register gates each extended source
// - level register picks high or low
// - taken interrupt vectors to fixed address
// - low routine preempted only by high
// - return pops back previous level state
// - vector only after current instruction ends
// - return or priority write delays one instruction
// - receiver ready rises set bits six, seven
// - global gate zero masks every interrupt
// - same level ties go to lowest number
`timescale 1ns/1ps
module eiu_top
  import eiu_pkg::*;
(
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  input  wire eiu_sfr_req_t sfr_req_in,
  output logic [7:0]        sfr_rdata_out,
  input  wire logic [5:0]   std_req_in,
  input  wire logic         converter_request_in,
  input  wire logic         serial_byte_request_in,
  input  wire logic         receiver_one_data_ready_in,
  input  wire logic         receiver_two_data_ready_in,
  input  wire logic         wake_timer_event_in,
  input  wire logic         instr_done_in,
  input  wire logic         instr_is_reti_in,
  output logic              irq_take_out,
  output logic [7:0]        irq_vector_out,
  output logic [1:0]        in_service_out
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] first_set(input logic [EIU_NUM_SRC-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = EIU_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [7:0] vec_of(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx < 4'(EIU_NUM_STD)) begin
      v = EIU_STD_VEC_BASE + 8'(idx) * EIU_VEC_STEP;
    end else begin
      v = EIU_EXT_VEC_BASE + 8'(idx - 4'(EIU_NUM_STD)) * EIU_VEC_STEP;
    end
    return v;
  endfunction

  // ==========================================================
  // source edges
  logic [4:0] ext_level;
  logic [4:0] ext_rise;

  assign ext_level = {wake_timer_event_in, receiver_two_data_ready_in,
                      receiver_one_data_ready_in, serial_byte_request_in,
                      converter_request_in};

  eiu_rise_det #(.W(EIU_NUM_EXT)) u_rise (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .level_in   (ext_level),
    .rise_out   (ext_rise)
  );

  // ==========================================================
  // register writes
  logic       wr_flags;
  logic       wr_ctrl;
  logic       wr_prio;
  assign wr_flags = sfr_req_in.wr && (sfr_req_in.addr == EIU_ADDR_FLAGS);
  assign wr_ctrl  = sfr_req_in.wr && (sfr_req_in.addr == EIU_ADDR_CONTROL);
  assign wr_prio  = sfr_req_in.wr && ((sfr_req_in.addr == EIU_ADDR_STD_MASK) ||
                    (sfr_req_in.addr == EIU_ADDR_STD_LEVEL) ||
                    (sfr_req_in.addr == EIU_ADDR_ENABLES) ||
                    (sfr_req_in.addr == EIU_ADDR_LEVELS));

  logic [4:0] ext_flag_q, ext_flag_d;
  logic [4:0] ext_en_q, ext_en_d;
  logic [4:0] ext_lv_q, ext_lv_d;
  logic [5:0] std_en_q, std_en_d;
  logic [5:0] std_lv_q, std_lv_d;
  logic       gate_q, gate_d;

  always_comb begin
    ext_flag_d = ext_flag_q;
    ext_en_d   = ext_en_q;
    ext_lv_d   = ext_lv_q;
    std_en_d   = std_en_q;
    std_lv_d   = std_lv_q;
    gate_d     = gate_q;
    if (wr_flags) begin
      ext_flag_d[3:0] = sfr_req_in.wdata[7:EIU_FLAGS_LSB];
    end
    if (wr_ctrl) begin
      ext_flag_d[4] = sfr_req_in.wdata[EIU_WAKE_BIT];
    end
    ext_flag_d = ext_flag_d | ext_rise;
    if (sfr_req_in.wr) begin
      unique case (sfr_req_in.addr)
        EIU_ADDR_ENABLES:   ext_en_d = sfr_req_in.wdata[4:0];
        EIU_ADDR_LEVELS:    ext_lv_d = sfr_req_in.wdata[4:0];
        EIU_ADDR_STD_MASK: begin
          std_en_d = sfr_req_in.wdata[5:0];
          gate_d   = sfr_req_in.wdata[EIU_GATE_BIT];
        end
        EIU_ADDR_STD_LEVEL: std_lv_d = sfr_req_in.wdata[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_flag_q <= EIU_EXT_RESET;
      ext_en_q   <= EIU_EXT_RESET;
      ext_lv_q   <= EIU_EXT_RESET;
      std_en_q   <= EIU_STD_RESET;
      std_lv_q   <= EIU_STD_RESET;
      gate_q     <= 1'b0;
    end else begin
      ext_flag_q <= ext_flag_d;
      ext_en_q   <= ext_en_d;
      ext_lv_q   <= ext_lv_d;
      std_en_q   <= std_en_d;
      std_lv_q   <= std_lv_d;
      gate_q     <= gate_d;
    end
  end

  // ==========================================================
  // register reads
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (sfr_req_in.rd) begin
      unique case (sfr_req_in.addr)
        EIU_ADDR_FLAGS:     rdata_d = {ext_flag_q[3:0], EIU_FLAGS_FIXED};
        EIU_ADDR_CONTROL:   rdata_d = {EIU_CTRL_TOP, 2'h0, ext_flag_q[4], 3'h0};
        EIU_ADDR_ENABLES:   rdata_d = {EIU_EXT_TOP, ext_en_q};
        EIU_ADDR_LEVELS:    rdata_d = {EIU_EXT_TOP, ext_lv_q};
        EIU_ADDR_STD_MASK:  rdata_d = {gate_q, EIU_STD_MASK_TOP[0], std_en_q};
        EIU_ADDR_STD_LEVEL: rdata_d = {EIU_STD_LEVEL_TOP, std_lv_q};
        default:            rdata_d = EIU_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_out = rdata_q;

  // ==========================================================
  // arbitration
  logic [EIU_NUM_SRC-1:0] req_all, en_all, lv_all, hi_cand, lo_cand;
  logic       act_hi_q, act_hi_d;
  logic       act_lo_q, act_lo_d;
  logic       pick_valid, pick_hi;
  logic [3:0] pick_idx;

  assign req_all = {ext_flag_q, std_req_in};
  assign en_all  = {ext_en_q, std_en_q} & {EIU_NUM_SRC{gate_q}};
  assign lv_all  = {ext_lv_q, std_lv_q};
  assign hi_cand = req_all & en_all & lv_all;
  assign lo_cand = req_all & en_all & ~lv_all;

  always_comb begin
    pick_valid = 1'b0;
    pick_hi    = 1'b0;
    pick_idx   = 4'h0;
    if ((|hi_cand) && !act_hi_q) begin
      pick_valid = 1'b1;
      pick_hi    = 1'b1;
      pick_idx   = first_set(hi_cand);
    end else if ((|lo_cand) && !act_hi_q && !act_lo_q) begin
      pick_valid = 1'b1;
      pick_idx   = first_set(lo_cand);
    end
  end

  // ==========================================================
  // vectoring and level stack
  logic       wrote_q, wrote_d;
  logic       take_ok;
  logic       reti_end;
  logic       take_q, take_d;
  logic [7:0] vec_q, vec_d;

  assign reti_end = instr_done_in && instr_is_reti_in;
  assign take_ok  = instr_done_in && !instr_is_reti_in && !wrote_q && !wr_prio
                    && pick_valid;

  always_comb begin
    wrote_d  = instr_done_in ? 1'b0 : (wrote_q || wr_prio);
    take_d   = take_ok;
    vec_d    = take_ok ? vec_of(pick_idx) : vec_q;
    act_hi_d = act_hi_q;
    act_lo_d = act_lo_q;
    if (reti_end) begin
      if (act_hi_q) begin
        act_hi_d = 1'b0;
      end else begin
        act_lo_d = 1'b0;
      end
    end
    if (take_ok) begin
      if (pick_hi) begin
        act_hi_d = 1'b1;
      end else begin
        act_lo_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wrote_q  <= 1'b0;
      take_q   <= 1'b0;
      vec_q    <= 8'h00;
      act_hi_q <= 1'b0;
      act_lo_q <= 1'b0;
    end else begin
      wrote_q  <= wrote_d;
      take_q   <= take_d;
      vec_q    <= vec_d;
      act_hi_q <= act_hi_d;
      act_lo_q <= act_lo_d;
    end
  end

  assign irq_take_out   = take_q;
  assign irq_vector_out = vec_q;
  assign in_service_out = {act_hi_q, act_lo_q};

  // ==========================================================
  // assertions
  property p_spi_flag;
    @(posedge ref_clk_in) disable iff (rst_in)
      (serial_byte_request_in && !$past(serial_byte_request_in)) |=> ext_flag_q[1];
  endproperty
  a_spi_flag: assert property (p_spi_flag) else $error("spi flag not set");

  property p_adc_flag;
    @(posedge ref_clk_in) disable iff (rst_in)
      (converter_request_in && !$past(converter_request_in)) |=> ext_flag_q[0];
  endproperty
  a_adc_flag: assert property (p_adc_flag) else $error("adc flag not set");

  property p_flag_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
      (ext_flag_q[3:0] != 4'h0 && !wr_flags) |=> ((ext_flag_q[3:0] & $past(ext_flag_q[3:0]))
        == $past(ext_flag_q[3:0]));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without write");

  property p_fixed_read;
    @(posedge ref_clk_in) disable iff (rst_in)
      (sfr_req_in.rd && sfr_req_in.addr == EIU_ADDR_FLAGS) |=> sfr_rdata_out[3:0] == 4'h8;
  endproperty
  a_fixed_read: assert property (p_fixed_read) else $error("reserved flag bits wrong");

  property p_wake_flag;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wake_timer_event_in && !$past(wake_timer_event_in)) |=> ext_flag_q[4];
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set");

  property p_clear_race;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_flags && sfr_req_in.wdata[4] == 1'b0 && ext_rise[0]) |=> ext_flag_q[0];
  endproperty
  a_clear_race: assert property (p_clear_race) else $error("set lost to clear");

  property p_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
      !gate_q |=> !irq_take_out;
  endproperty
  a_gate: assert property (p_gate) else $error("take while gate off");

  property p_no_preempt_hi;
    @(posedge ref_clk_in) disable iff (rst_in)
      (act_hi_q && !reti_end) |=> !irq_take_out;
  endproperty
  a_no_preempt_hi: assert property (p_no_preempt_hi) else $error("high preempted");

  property p_take_at_end;
    @(posedge ref_clk_in) disable iff (rst_in)
      irq_take_out |-> $past(instr_done_in) && !$past(instr_is_reti_in);
  endproperty
  a_take_at_end: assert property (p_take_at_end) else $error("take mid instr");

  property p_adc_vector;
    @(posedge ref_clk_in) disable iff (rst_in)
      (take_ok && pick_idx == 4'h6) |=> irq_take_out && irq_vector_out == 8'h43;
  endproperty
  a_adc_vector: assert property (p_adc_vector) else $error("adc vector wrong");

  property p_reti_pop;
    @(posedge ref_clk_in) disable iff (rst_in)
      (reti_end && act_hi_q && act_lo_q) |=> !act_hi_q && act_lo_q;
  endproperty
  a_reti_pop: assert property (p_reti_pop) else $error("level not restored");

  c_take_lo: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    take_ok && !pick_hi);
  c_nested: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    act_lo_q && take_ok && pick_hi);
  c_reti_hold: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    reti_end && pick_valid);
  c_wake_take: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    take_ok && pick_idx == 4'hA);

endmodule

// File: verification/eiu_cpu_model.sv
`timescale 1ns/1ps
module eiu_cpu_model (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic step_in,
  input  wire logic reti_in,
  output logic      instr_done_out,
  output logic      instr_is_reti_out
);
  // ======================================
  // instruction end strobe, one per step request
  logic done_q;
  logic reti_q;
  logic junk_q;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
      reti_q <= 1'b0;
      junk_q <= 1'b0;
    end else begin
      done_q <= step_in;
      reti_q <= reti_in;
      junk_q <= ~junk_q;
    end
  end

  assign instr_done_out    = done_q;
  // qualifier is meaningless outside the strobe, so it toggles there
  assign instr_is_reti_out = done_q ? reti_q : junk_q;
endmodule

// File: verification/test_extended_interrupt_unit.sv
`timescale 1ns/1ps
module test_extended_interrupt_unit
  import eiu_pkg::*;
;
  // ======================================
  // signals
  logic         ref_clk_in;
  logic         rst_in;
  eiu_sfr_req_t req;
  logic [7:0]   rdata;
  logic [5:0]   std_req;
  logic         conv;
  logic         spi;
  logic         r1;
  logic         r2;
  logic         wake;
  logic         step_q;
  logic         reti;
  logic         done;
  logic         is_reti;
  logic         take;
  logic [7:0]   vec;
  logic [1:0]   ins;
  int           fails;
  int           checks;
  logic [7:0]   ra[7];
  logic [7:0]   rv[7];

  eiu_top uut (
    .ref_clk_in                 (ref_clk_in),
    .rst_in                     (rst_in),
    .sfr_req_in                 (req),
    .sfr_rdata_out              (rdata),
    .std_req_in                 (std_req),
    .converter_request_in       (conv),
    .serial_byte_request_in     (spi),
    .receiver_one_data_ready_in (r1),
    .receiver_two_data_ready_in (r2),
    .wake_timer_event_in        (wake),
    .instr_done_in              (done),
    .instr_is_reti_in           (is_reti),
    .irq_take_out               (take),
    .irq_vector_out             (vec),
    .in_service_out             (ins)
  );

  eiu_cpu_model cpu (
    .ref_clk_in        (ref_clk_in),
    .rst_in            (rst_in),
    .step_in           (step_q),
    .reti_in           (reti),
    .instr_done_out    (done),
    .instr_is_reti_out (is_reti)
  );

  always #10 ref_clk_in = ~ref_clk_in;

  // ======================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge ref_clk_in);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge ref_clk_in);
    req.rd <= 1'b0;
    @(negedge ref_clk_in);
    chk(rdata, exp);
  endtask

  // one instruction end; exp 8'h00 means no interrupt taken
  task automatic step(input logic r, input logic [7:0] exp, input logic [1:0] svc);
    logic [7:0] got;
    got = 8'h00;
    @(posedge ref_clk_in);
    step_q <= 1'b1;
    reti <= r;
    @(posedge ref_clk_in);
    step_q <= 1'b0;
    repeat (4) begin
      @(negedge ref_clk_in);
      if (take === 1'b1) got = vec;
    end
    chk(got, exp);
    chk({6'h00, ins}, {6'h00, svc});
  endtask

  task automatic stop_test;
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ======================================
  // main sequence
  initial begin
    ref_clk_in = 1'b0;
    rst_in = 1'b1;
    req = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    {std_req, conv, spi, r1, r2, wake, step_q, reti} = 13'h0000;
    fails = 0;
    checks = 0;
    ra = '{EIU_ADDR_FLAGS, EIU_ADDR_CONTROL, EIU_ADDR_ENABLES, EIU_ADDR_LEVELS,
           EIU_ADDR_STD_MASK, EIU_ADDR_STD_LEVEL, 8'h90};
    rv = '{8'h08, 8'h40, 8'hE0, 8'hE0, 8'h00, 8'h80, 8'h00};
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    @(posedge ref_clk_in);
    {r2, r1, spi, conv, wake} <= 5'h1F;
    rd(EIU_ADDR_FLAGS, 8'hF8);
    rd(EIU_ADDR_CONTROL, 8'h48);
    @(posedge ref_clk_in);
    {r2, r1, spi, conv, wake} <= 5'h00;
    wr(EIU_ADDR_CONTROL, 8'h00);
    @(posedge ref_clk_in);
    req <= '{addr: EIU_ADDR_FLAGS, wr: 1'b1, rd: 1'b0, wdata: 8'h00};
    conv <= 1'b1;
    @(posedge ref_clk_in);
    req.wr <= 1'b0;
    conv <= 1'b0;
    rd(EIU_ADDR_FLAGS, 8'h18);
    rd(EIU_ADDR_CONTROL, 8'h40);
    wr(EIU_ADDR_FLAGS, 8'hE0);
    rd(EIU_ADDR_FLAGS, 8'hE8);
    wr(EIU_ADDR_ENABLES, 8'h1F);
    wr(EIU_ADDR_FLAGS, 8'h10);
    step(1'b0, 8'h00, 2'h0);
    step(1'b0, 8'h00, 2'h0);
    wr(EIU_ADDR_STD_MASK, 8'hBF);
    step(1'b0, 8'h00, 2'h0);
    step(1'b0, 8'h43, 2'h1);
    wr(EIU_ADDR_FLAGS, 8'h00);
    step(1'b1, 8'h00, 2'h0);
    for (int i = 0; i < 11; i++) begin
      if (i < 6) @(posedge ref_clk_in) std_req <= 6'(1 << i);
      else if (i < 10) wr(EIU_ADDR_FLAGS, 8'(8'h10 << (i - 6)));
      else wr(EIU_ADDR_CONTROL, 8'h08);
      step(1'b0, (i < 6) ? 8'(3 + 8 * i) : 8'(67 + 8 * (i - 6)), 2'h1);
      @(posedge ref_clk_in) std_req <= 6'h00;
      wr(EIU_ADDR_FLAGS, 8'h00);
      wr(EIU_ADDR_CONTROL, 8'h00);
      step(1'b1, 8'h00, 2'h0);
    end
    wr(EIU_ADDR_ENABLES, 8'h1E);
    wr(EIU_ADDR_FLAGS, 8'h30);
    step(1'b0, 8'h00, 2'h0);
    step(1'b0, 8'h4B, 2'h1);
    wr(EIU_ADDR_ENABLES, 8'h1F);
    step(1'b1, 8'h00, 2'h0);
    step(1'b0, 8'h43, 2'h1);
    step(1'b0, 8'h00, 2'h1);
    wr(EIU_ADDR_LEVELS, 8'h12);
    rd(EIU_ADDR_LEVELS, 8'hF2);
    step(1'b0, 8'h00, 2'h1);
    step(1'b0, 8'h4B, 2'h3);
    wr(EIU_ADDR_FLAGS, 8'h10);
    wr(EIU_ADDR_CONTROL, 8'h08);
    step(1'b0, 8'h00, 2'h3);
    step(1'b1, 8'h00, 2'h1);
    step(1'b0, 8'h63, 2'h3);
    step(1'b1, 8'h00, 2'h1);
    step(1'b0, 8'h63, 2'h3);
    wr(EIU_ADDR_CONTROL, 8'h00);
    wr(EIU_ADDR_STD_LEVEL, 8'hFF);
    rd(EIU_ADDR_STD_LEVEL, 8'hBF);
    step(1'b1, 8'h00, 2'h1);
    @(posedge ref_clk_in);
    std_req <= 6'h21;
    step(1'b0, 8'h03, 2'h3);
    @(posedge ref_clk_in);
    std_req <= 6'h00;
    stop_test();
  end
endmodule
